// >>> pccr_regs.sv
// PWM channel configuration register bank, two channels
`timescale 1ns/1ps
// Operation
// RQ1: Clocking register writes taken only with both channels off, else busy.
// RQ2: Share clock bit 0: line enabled once input reaches start threshold.
// RQ3: Share clock bit 1: line low at stop threshold until start threshold.
// RQ4: Phase field selects channel phases and maximum duty cycle.
// RQ5: Run bit 0: off command pulses run low for the computed time.
// RQ6: Run bit 1: no run pulse on off command.
// RQ7: Short-cycle bit 0: on and off commands followed as they arrive.
// RQ8: Short-cycle bit 1: re-on in turn-off aborts, then 120ms off.
// RQ9: Gate bit 1: output disabled while share clock line is low.
// RQ10: Host writes reserved bits as zero.
// RQ11: Decay bit 0: retry waits for output decay to 12.5 percent.
// RQ12: Mode register writes taken only with addressed channels off.
// RQ13: Mode bit 7 selects output range 5.25V or 2.65V.
// RQ14: Mode bit 6 enables servo unless load-line setting is nonzero.
// RQ15: Mode bit 5 clear selects base-emitter difference temperature method.
// RQ16: Mode bit 5 set selects direct voltage temperature method.
// RQ17: Mode bit 1 selects plain or no-discontinuous three-state protocol.
// RQ18: Mode bit 0 selects continuous or discontinuous conduction.
// RQ19: Registers reached at command codes 0xF5, 0xD0, 0xD4.
// RQ20: Defaults 0x14, 0x1D and 0xC8.
// RQ21: Reads return last accepted value; busy writes leave it unchanged.
module pccr_regs #(
  parameter int TW = pccr_pkg::PCCR_TW,
  parameter int RUN_EXTRA_CYC = pccr_pkg::PCCR_RUN_EXTRA_CYC,
  parameter int MIN_OFF_CYC = pccr_pkg::PCCR_MIN_OFF_CYC
) (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire pccr_pkg::pccr_req_t REQ,
  output logic [7:0] RD_DATA,
  output logic RD_VALID,
  output logic CMD_NACK,
  output logic BUSY_FAULT,
  input wire logic [1:0] CHAN_RUNNING,
  input wire logic [1:0] CHAN_CMD_ON,
  input wire logic [1:0] CHAN_IN_TOFF,
  input wire logic [1:0] LOAD_LINE_NONZERO,
  input wire logic [2*TW-1:0] TOFF_TOTAL_CYC,
  input wire logic [2*TW-1:0] RESTART_CYC,
  input wire logic INPUT_AT_START,
  input wire logic INPUT_AT_STOP,
  input wire logic INIT_DONE,
  output logic SHARED_CLOCK_LINE_EN,
  output logic [2:0] PHASE_SEL,
  output logic [7:0] PHASE0_DEG,
  output logic [8:0] PHASE1_DEG,
  output logic DUTY_875,
  output logic [1:0] RUN_PULSE_N,
  output logic [1:0] OUT_ENABLE,
  output pccr_pkg::pccr_chan_ctl_t [1:0] CHAN_CTL
);
  import pccr_pkg::*;

  logic [7:0] clk_cfg_q, clk_cfg_d;
  logic [1:0][7:0] chan_cfg_q, chan_cfg_d;
  logic [1:0][7:0] mode_q, mode_d;
  logic [7:0] rd_data_q, rd_data_d;
  logic rd_valid_q, rd_valid_d;
  logic nack_q, nack_d;
  logic busy_q, busy_d;
  logic share_en_q, share_en_d;
  logic [1:0] sel;
  logic wr_busy;

  // Channels a paged command addresses
  always_comb begin
    sel = REQ.all_pages ? 2'b11 : (REQ.page ? 2'b10 : 2'b01);
  end

  always_comb begin
    clk_cfg_d = clk_cfg_q;
    chan_cfg_d = chan_cfg_q;
    mode_d = mode_q;
    rd_data_d = rd_data_q;
    rd_valid_d = 1'b0;
    nack_d = 1'b0;
    busy_d = busy_q;
    wr_busy = 1'b0;
    if (REQ.wr) begin
      case (REQ.cmd)
        PCCR_CMD_CLOCKING: begin
          if (CHAN_RUNNING != 2'b00) begin
            wr_busy = 1'b1; // RQ1
          end else begin
            // Reserved bits stored as zero; host should send zero
            clk_cfg_d = REQ.data & PCCR_CLK_WMASK; // RQ10
          end
        end
        PCCR_CMD_CHAN_CFG: begin
          for (int i = 0; i < 2; i++) begin
            if (sel[i]) begin
              chan_cfg_d[i] = REQ.data & PCCR_CFG_WMASK; // RQ10
            end
          end
        end
        PCCR_CMD_MODE: begin
          if ((CHAN_RUNNING & sel) != 2'b00) begin
            wr_busy = 1'b1; // RQ12
          end else begin
            for (int i = 0; i < 2; i++) begin
              if (sel[i]) begin
                mode_d[i] = REQ.data;
              end
            end
          end
        end
        default: begin
        end
      endcase
    end
    if (wr_busy) begin
      // Register left as is; flag stays until reset
      nack_d = 1'b1; // RQ1 RQ12 RQ21
      busy_d = 1'b1;
    end
    if (REQ.rd) begin
      rd_valid_d = 1'b1;
      case (REQ.cmd)
        PCCR_CMD_CLOCKING: rd_data_d = clk_cfg_q; // RQ19 RQ21
        PCCR_CMD_CHAN_CFG: rd_data_d = chan_cfg_q[REQ.page];
        PCCR_CMD_MODE: rd_data_d = mode_q[REQ.page];
        default: begin
          rd_data_d = 8'h00;
          nack_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      clk_cfg_q <= PCCR_RST_CLOCKING; // RQ20
      chan_cfg_q <= {2{PCCR_RST_CHAN_CFG}};
      mode_q <= {2{PCCR_RST_MODE}};
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
      nack_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      clk_cfg_q <= clk_cfg_d;
      chan_cfg_q <= chan_cfg_d;
      mode_q <= mode_d;
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      nack_q <= nack_d;
      busy_q <= busy_d;
    end
  end

  assign RD_DATA = rd_data_q;
  assign RD_VALID = rd_valid_q;
  assign CMD_NACK = nack_q;
  assign BUSY_FAULT = busy_q;

  // Share clock line enable
  always_comb begin
    share_en_d = share_en_q;
    if (!INIT_DONE) begin
      share_en_d = 1'b0;
    end else if (INPUT_AT_START) begin
      share_en_d = 1'b1; // RQ2 RQ3
    end else if (clk_cfg_q[PCCR_CLK_SHARE_BIT] && INPUT_AT_STOP) begin
      share_en_d = 1'b0; // RQ3
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      share_en_q <= 1'b0;
    end else begin
      share_en_q <= share_en_d;
    end
  end

  assign SHARED_CLOCK_LINE_EN = share_en_q;

  // Phase decode; zero pattern has no documented meaning
  logic [7:0] ph0_d;
  logic [8:0] ph1_d;
  logic [7:0] ph0_q;
  logic [8:0] ph1_q;
  logic duty_d, duty_q;
  always_comb begin
    duty_d = clk_cfg_q[2]; // RQ4
    case (clk_cfg_q[2:0])
      3'h7: begin
        ph0_d = 8'h87;
        ph1_d = 9'h13b;
      end
      3'h6: begin
        ph0_d = 8'h5a;
        ph1_d = 9'h10e;
      end
      3'h5: begin
        ph0_d = 8'h2d;
        ph1_d = 9'h0e1;
      end
      3'h3: begin
        ph0_d = 8'h78;
        ph1_d = 9'h12c;
      end
      3'h2: begin
        ph0_d = 8'h3c;
        ph1_d = 9'h0f0;
      end
      default: begin
        ph0_d = 8'h00;
        ph1_d = 9'h0b4;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ph0_q <= 8'h00;
      ph1_q <= 9'h0b4;
      duty_q <= 1'b1;
    end else begin
      ph0_q <= ph0_d;
      ph1_q <= ph1_d;
      duty_q <= duty_d;
    end
  end

  assign PHASE_SEL = clk_cfg_q[2:0];
  assign PHASE0_DEG = ph0_q;
  assign PHASE1_DEG = ph1_q;
  assign DUTY_875 = duty_q;

  // Per-channel controls and sequencers
  for (genvar g = 0; g < 2; g++) begin : g_chan
    assign CHAN_CTL[g].low_range = mode_q[g][PCCR_MODE_RANGE_BIT]; // RQ13
    // Load line forces servo off
    assign CHAN_CTL[g].servo_en = mode_q[g][PCCR_MODE_SERVO_BIT]
      && !LOAD_LINE_NONZERO[g]; // RQ14
    assign CHAN_CTL[g].temp_direct = mode_q[g][PCCR_MODE_TEMP_BIT]; // RQ15 RQ16
    assign CHAN_CTL[g].no_dcm_roc = mode_q[g][PCCR_MODE_PROTO_BIT]; // RQ17
    // Protocol bit overrides conduction mode
    assign CHAN_CTL[g].dcm_allowed = mode_q[g][PCCR_MODE_CONDUCT_BIT]
      && !mode_q[g][PCCR_MODE_PROTO_BIT]; // RQ18
    assign CHAN_CTL[g].decay_needed = !chan_cfg_q[g][PCCR_CFG_DECAY_BIT]; // RQ11
    assign CHAN_CTL[g].boost_width = mode_q[g][4:3];

    pccr_chan_seq #(
      .TW(TW),
      .RUN_EXTRA_CYC(RUN_EXTRA_CYC),
      .MIN_OFF_CYC(MIN_OFF_CYC)
    ) u_seq (
      .clk(REF_CLK),
      .arst_n(ARST_N),
      .cmd_on(CHAN_CMD_ON[g]),
      .in_toff(CHAN_IN_TOFF[g]),
      .toff_total_cyc(TOFF_TOTAL_CYC[g*TW +: TW]),
      .restart_cyc(RESTART_CYC[g*TW +: TW]),
      .no_run_pulse(chan_cfg_q[g][PCCR_CFG_RUN_BIT]),
      .short_cycle(chan_cfg_q[g][PCCR_CFG_SHORT_BIT]),
      .gate_on_share(chan_cfg_q[g][PCCR_CFG_GATE_BIT]),
      .share_low(!share_en_q),
      .run_pulse_n(RUN_PULSE_N[g]),
      .out_enable(OUT_ENABLE[g])
    );
  end
endmodule

// >>> pccr_pkg.sv
// Constants and types for the PWM channel configuration register bank
package pccr_pkg;
  localparam logic [7:0] PCCR_CMD_CLOCKING = 8'hf5;
  localparam logic [7:0] PCCR_CMD_CHAN_CFG = 8'hd0;
  localparam logic [7:0] PCCR_CMD_MODE = 8'hd4;
  localparam logic [7:0] PCCR_RST_CLOCKING = 8'h14;
  localparam logic [7:0] PCCR_RST_CHAN_CFG = 8'h1d;
  localparam logic [7:0] PCCR_RST_MODE = 8'hc8;
  // Field positions
  localparam int PCCR_CLK_SHARE_BIT = 4;
  localparam int PCCR_CFG_RUN_BIT = 4;
  localparam int PCCR_CFG_SHORT_BIT = 3;
  localparam int PCCR_CFG_GATE_BIT = 2;
  localparam int PCCR_CFG_DECAY_BIT = 0;
  localparam int PCCR_MODE_RANGE_BIT = 7;
  localparam int PCCR_MODE_SERVO_BIT = 6;
  localparam int PCCR_MODE_TEMP_BIT = 5;
  localparam int PCCR_MODE_PROTO_BIT = 1;
  localparam int PCCR_MODE_CONDUCT_BIT = 0;
  localparam logic [7:0] PCCR_CLK_WMASK = 8'h3f;
  localparam logic [7:0] PCCR_CFG_WMASK = 8'hfd;
  // Timing
  localparam int PCCR_CLK_MHZ = 250;
  localparam int PCCR_RUN_EXTRA_MS = 136;
  localparam int PCCR_MIN_OFF_MS = 120;
  localparam int PCCR_RUN_EXTRA_CYC = PCCR_RUN_EXTRA_MS * 1000 * PCCR_CLK_MHZ;
  localparam int PCCR_MIN_OFF_CYC = PCCR_MIN_OFF_MS * 1000 * PCCR_CLK_MHZ;
  localparam int PCCR_TW = 32;

  // Register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] cmd;
    logic page;
    logic all_pages;
    logic [7:0] data;
  } pccr_req_t;

  // Per-channel decoded controls
  typedef struct packed {
    logic low_range;
    logic servo_en;
    logic temp_direct;
    logic no_dcm_roc;
    logic dcm_allowed;
    logic decay_needed;
    logic [1:0] boost_width;
  } pccr_chan_ctl_t;
endpackage

// >>> pccr_chan_seq.sv
// Per-channel run pulse and short-cycle sequencing
`timescale 1ns/1ps
module pccr_chan_seq #(
  parameter int TW = pccr_pkg::PCCR_TW,
  parameter int RUN_EXTRA_CYC = pccr_pkg::PCCR_RUN_EXTRA_CYC,
  parameter int MIN_OFF_CYC = pccr_pkg::PCCR_MIN_OFF_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cmd_on,
  input wire logic in_toff,
  input wire logic [TW-1:0] toff_total_cyc,
  input wire logic [TW-1:0] restart_cyc,
  input wire logic no_run_pulse,
  input wire logic short_cycle,
  input wire logic gate_on_share,
  input wire logic share_low,
  output logic run_pulse_n,
  output logic out_enable
);
  import pccr_pkg::*;

  logic cmd_on_q, cmd_on_d;
  logic [TW-1:0] run_cnt_q, run_cnt_d;
  logic [TW-1:0] off_cnt_q, off_cnt_d;
  logic [TW-1:0] pulse_len;
  logic reon;

  always_comb begin
    // Re-on during turn-off: abort and hold off
    reon = !cmd_on_q && cmd_on && short_cycle && in_toff;
    pulse_len = toff_total_cyc + TW'(RUN_EXTRA_CYC);
    if (restart_cyc > pulse_len) begin
      pulse_len = restart_cyc;
    end
    cmd_on_d = cmd_on;
    run_cnt_d = run_cnt_q;
    off_cnt_d = off_cnt_q;
    if (run_cnt_q != '0) begin
      run_cnt_d = run_cnt_q - TW'(1);
    end
    if (off_cnt_q != '0) begin
      off_cnt_d = off_cnt_q - TW'(1);
    end
    // Falling edge of the on command starts the run pulse
    if (cmd_on_q && !cmd_on && !no_run_pulse) begin
      run_cnt_d = pulse_len; // RQ5
    end
    if (reon) begin
      off_cnt_d = TW'(MIN_OFF_CYC); // RQ8
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_on_q <= 1'b0;
      run_cnt_q <= '0;
      off_cnt_q <= '0;
    end else begin
      cmd_on_q <= cmd_on_d;
      run_cnt_q <= run_cnt_d;
      off_cnt_q <= off_cnt_d;
    end
  end

  // No pulse at all when the channel is set to skip it
  assign run_pulse_n = (run_cnt_q == '0) || no_run_pulse; // RQ5 RQ6
  // Without short-cycle, the command passes straight through unless the share clock gate blocks it
  // Dark in the re-on cycle too, before the hold counter has loaded
  assign out_enable = cmd_on && (off_cnt_q == '0) && !reon // RQ7 RQ8
    && (run_cnt_q == '0 || !short_cycle)
    && !(gate_on_share && share_low); // RQ9
endmodule

// >>> pccr_regs_sva.sv
// Assertions on the register bank ports
`timescale 1ns/1ps
module pccr_regs_chk (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire pccr_pkg::pccr_req_t REQ,
  input wire logic RD_VALID,
  input wire logic CMD_NACK,
  input wire logic BUSY_FAULT,
  input wire logic [1:0] CHAN_RUNNING,
  input wire logic [1:0] LOAD_LINE_NONZERO,
  input wire logic [1:0] CHAN_CMD_ON,
  input wire logic INPUT_AT_START,
  input wire logic INIT_DONE,
  input wire logic SHARED_CLOCK_LINE_EN,
  input wire logic DUTY_875,
  input wire logic [1:0] OUT_ENABLE,
  input wire logic [2:0] PHASE_SEL,
  input wire logic [7:0] PHASE0_DEG,
  input wire logic [8:0] PHASE1_DEG,
  input wire pccr_pkg::pccr_chan_ctl_t [1:0] CHAN_CTL
);
  import pccr_pkg::*;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!ARST_N);
  sequence s_refused;
    CMD_NACK && BUSY_FAULT;
  endsequence
  sequence s_clk_wr;
    REQ.wr && REQ.cmd == PCCR_CMD_CLOCKING;
  endsequence
  a_clk_busy: assert property (
    s_clk_wr ##0 CHAN_RUNNING != 2'h0 |=> s_refused)
    else $error("clocking write while running not refused");
  a_clk_quiet: assert property (
    s_clk_wr ##0 (CHAN_RUNNING == 2'h0 && !REQ.rd) |=> !CMD_NACK)
    else $error("clocking write while idle refused");
  a_mode_busy: assert property (
    REQ.wr && REQ.cmd == PCCR_CMD_MODE && CHAN_RUNNING[REQ.page]
    |=> s_refused)
    else $error("mode write to running channel not refused");
  a_rd_answer: assert property (
    REQ.rd && !REQ.wr && REQ.cmd == PCCR_CMD_CLOCKING
    |=> RD_VALID && !CMD_NACK)
    else $error("clocking read not answered");
  a_busy_hold: assert property (
    BUSY_FAULT |=> BUSY_FAULT)
    else $error("busy fault dropped without reset");
  a_servo_gate: assert property (
    LOAD_LINE_NONZERO[0] |-> !CHAN_CTL[0].servo_en)
    else $error("servo left on with load line set");
  a_phase_max: assert property (
    PHASE_SEL == 3'h7 |=> PHASE0_DEG == 8'h87 && PHASE1_DEG == 9'h13b)
    else $error("phase code 7 decoded wrongly");
  a_phase_base: assert property (
    PHASE_SEL == 3'h4 |=> PHASE0_DEG == 8'h00 && PHASE1_DEG == 9'h0b4)
    else $error("phase code 4 decoded wrongly");
  a_share_start: assert property (
    INIT_DONE && INPUT_AT_START |=> SHARED_CLOCK_LINE_EN)
    else $error("share clock not enabled at start threshold");
  a_duty_code: assert property (
    PHASE_SEL[2] |=> DUTY_875)
    else $error("duty limit wrong for phase code");
  a_out_needs_on: assert property (
    !CHAN_CMD_ON[0] |-> !OUT_ENABLE[0])
    else $error("output enabled while commanded off");
endmodule
bind pccr_regs pccr_regs_chk chk_u (.REF_CLK, .ARST_N, .REQ, .RD_VALID,
  .CMD_NACK, .BUSY_FAULT, .CHAN_RUNNING, .LOAD_LINE_NONZERO, .PHASE_SEL,
  .PHASE0_DEG, .PHASE1_DEG, .CHAN_CTL, .CHAN_CMD_ON, .INPUT_AT_START,
  .INIT_DONE, .SHARED_CLOCK_LINE_EN, .DUTY_875, .OUT_ENABLE);

// >>> pccr_host.sv
// Host model issuing byte commands to the register bank
`timescale 1ns/1ps
module pccr_host (
  input wire logic clk,
  output pccr_pkg::pccr_req_t req
);
  import pccr_pkg::*;
  initial req = '0;
  // One request held over exactly one taking edge, then released
  task automatic xfer(input logic w, r, input logic [7:0] c,
                      input logic p, a, input logic [7:0] d);
    logic [7:0] m;
    m = (c == PCCR_CMD_CLOCKING) ? PCCR_CLK_WMASK :
        (c == PCCR_CMD_CHAN_CFG) ? PCCR_CFG_WMASK : 8'hff;
    @(posedge clk);
    #1 req = '{w, r, c, p, a, d & m};
    @(posedge clk);
    #1 req = '0;
  endtask
endmodule

// >>> pwm_channel_config_regs_tb.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
module pwm_channel_config_regs_tb;
  import pccr_pkg::*;
  typedef struct packed {
    logic w;
    logic [7:0] c;
    logic p;
    logic [7:0] d;
    logic [7:0] e;
  } pccr_row_t;
  pccr_row_t rows [6] = '{
    '{1'b0, PCCR_CMD_CLOCKING, 1'b0, 8'h00, PCCR_RST_CLOCKING},
    '{1'b0, PCCR_CMD_CHAN_CFG, 1'b0, 8'h00, PCCR_RST_CHAN_CFG},
    '{1'b0, PCCR_CMD_MODE, 1'b1, 8'h00, PCCR_RST_MODE},
    '{1'b1, PCCR_CMD_CLOCKING, 1'b0, 8'h27, 8'h27},
    '{1'b1, PCCR_CMD_CHAN_CFG, 1'b1, 8'h10, 8'h10},
    '{1'b1, PCCR_CMD_MODE, 1'b0, 8'h41, 8'h41}};
  logic ref_clk, arst_n, rd_valid, cmd_nack, busy_fault, input_at_start;
  logic shared_clock_line_en, duty_875;
  logic [1:0] chan_running, chan_cmd_on, load_line_nonzero;
  logic [1:0] chan_in_toff;
  logic input_at_stop, init_done;
  logic [1:0] run_pulse_n, out_enable;
  logic [2:0] phase_sel;
  logic [7:0] rd_data, phase0_deg;
  logic [8:0] phase1_deg;
  pccr_req_t req;
  pccr_chan_ctl_t [1:0] chan_ctl;
  int n_errors = 0;
  int compares = 0;
  int n0, n1;
  pccr_host h_u (.clk(ref_clk), .req(req));
  // Short counts keep the run pulse test brief
  pccr_regs #(.RUN_EXTRA_CYC(20), .MIN_OFF_CYC(10)) dut_u (
    .REF_CLK(ref_clk), .ARST_N(arst_n), .REQ(req), .RD_DATA(rd_data),
    .RD_VALID(rd_valid), .CMD_NACK(cmd_nack), .BUSY_FAULT(busy_fault),
    .CHAN_RUNNING(chan_running), .CHAN_CMD_ON(chan_cmd_on),
    .CHAN_IN_TOFF(chan_in_toff), .LOAD_LINE_NONZERO(load_line_nonzero),
    .TOFF_TOTAL_CYC({32'h3, 32'h5}), .RESTART_CYC({32'h3, 32'h3}),
    .INPUT_AT_START(input_at_start), .INPUT_AT_STOP(input_at_stop),
    .INIT_DONE(init_done), .SHARED_CLOCK_LINE_EN(shared_clock_line_en), .PHASE_SEL(phase_sel),
    .PHASE0_DEG(phase0_deg), .PHASE1_DEG(phase1_deg), .DUTY_875(duty_875),
    .RUN_PULSE_N(run_pulse_n), .OUT_ENABLE(out_enable),
    .CHAN_CTL(chan_ctl));
  task automatic chk(input string n, input logic [8:0] e, s);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic step;
    @(posedge ref_clk);
    #1;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Hang guard
  initial begin
    #200000;
    n_errors++;
    end_of_test;
  end
  initial begin
    arst_n = 1'b0;
    input_at_start = 1'b0;
    input_at_stop = 1'b0;
    init_done = 1'b0;
    chan_running = 2'h0;
    chan_in_toff = 2'h0;
    chan_cmd_on = 2'h3;
    load_line_nonzero = 2'h0;
    repeat (8) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    input_at_start = 1'b1;
    repeat (3) step;
    chk("share_pre_init", 1'b0, shared_clock_line_en);
    init_done = 1'b1;
    step;
    chk("share_en", 1'b1, shared_clock_line_en);
    for (int i = 0; i < 6; i++) begin
      if (rows[i].w)
        h_u.xfer(1'b1, 1'b0, rows[i].c, rows[i].p, 1'b0, rows[i].d);
      h_u.xfer(1'b0, 1'b1, rows[i].c, rows[i].p, 1'b0, 8'h00);
      chk("rd_data", rows[i].e, rd_data);
      chk("rd_valid", 1'b1, rd_valid);
    end
    chk("phase0", 8'h87, phase0_deg);
    chk("phase1", 9'h13b, phase1_deg);
    chk("duty", 1'b1, duty_875);
    chk("share_on", 1'b1, shared_clock_line_en);
    chk("servo", 1'b1, chan_ctl[0].servo_en);
    chk("dcm", 1'b1, chan_ctl[0].dcm_allowed);
    chk("phase_sel", 9'h007, phase_sel);
    chk("range_hi", 1'b0, chan_ctl[0].low_range);
    chk("temp_dvbe", 1'b0, chan_ctl[0].temp_direct);
    chk("proto_plain", 1'b0, chan_ctl[0].no_dcm_roc);
    chk("decay_off", 1'b0, chan_ctl[0].decay_needed);
    step;
    load_line_nonzero = 2'h1;
    step;
    chk("servo_off", 1'b0, chan_ctl[0].servo_en);
    chan_running = 2'h1;
    h_u.xfer(1'b1, 1'b0, PCCR_CMD_CLOCKING, 1'b0, 1'b0, 8'h05);
    chk("clk_nack", 1'b1, cmd_nack);
    chk("busy", 1'b1, busy_fault);
    h_u.xfer(1'b0, 1'b1, PCCR_CMD_CLOCKING, 1'b0, 1'b0, 8'h00);
    chk("clk_kept", 8'h27, rd_data);
    h_u.xfer(1'b1, 1'b0, PCCR_CMD_MODE, 1'b0, 1'b0, 8'h00);
    chk("mode_nack", 1'b1, cmd_nack);
    h_u.xfer(1'b1, 1'b0, PCCR_CMD_MODE, 1'b1, 1'b0, 8'h01);
    chk("mode_ok", 1'b0, cmd_nack);
    h_u.xfer(1'b0, 1'b1, PCCR_CMD_MODE, 1'b1, 1'b0, 8'h00);
    chk("mode_rd", 8'h01, rd_data);
    h_u.xfer(1'b0, 1'b1, 8'h33, 1'b0, 1'b0, 8'h00);
    chk("unknown", 1'b1, cmd_nack);
    chan_running = 2'h0;
    h_u.xfer(1'b1, 1'b0, PCCR_CMD_CHAN_CFG, 1'b0, 1'b0, 8'h00);
    step;
    chan_cmd_on = 2'h0;
    n0 = 0;
    n1 = 0;
    // Bounded count of low cycles on both run outputs
    for (int i = 0; i < 60; i++) begin
      step;
      if (run_pulse_n[0] !== 1'b1)
        n0++;
      if (run_pulse_n[1] !== 1'b1)
        n1++;
    end
    chk("pulse0", 9'h019, 9'(n0));
    chk("pulse1", 9'h000, 9'(n1));
    // Both pages at once, then every decoded mode field but servo, plus decay
    h_u.xfer(1'b1, 1'b0, PCCR_CMD_MODE, 1'b0, 1'b1, 8'hba);
    h_u.xfer(1'b0, 1'b1, PCCR_CMD_MODE, 1'b1, 1'b0, 8'h00);
    chk("mode_all", 8'hba, rd_data);
    chk("range_lo", 1'b1, chan_ctl[0].low_range);
    chk("temp_dir", 1'b1, chan_ctl[0].temp_direct);
    chk("proto", 1'b1, chan_ctl[0].no_dcm_roc);
    chk("ccm", 1'b0, chan_ctl[0].dcm_allowed);
    chk("boost", 2'h3, chan_ctl[0].boost_width);
    chk("decay", 1'b1, chan_ctl[0].decay_needed);
    // An 83.3 percent code with the stop-threshold share mode
    h_u.xfer(1'b1, 1'b0, PCCR_CMD_CLOCKING, 1'b0, 1'b0, 8'h13);
    step;
    chk("phase0_b", 8'h78, phase0_deg);
    chk("phase1_b", 9'h12c, phase1_deg);
    chk("duty_b", 1'b0, duty_875);
    h_u.xfer(1'b1, 1'b0, PCCR_CMD_CHAN_CFG, 1'b0, 1'b0, 8'h14);
    input_at_start = 1'b0;
    input_at_stop = 1'b1;
    chan_cmd_on = 2'h3;
    step;
    chk("share_drop", 1'b0, shared_clock_line_en);
    chk("gated", 2'h2, out_enable);
    input_at_stop = 1'b0;
    step;
    chk("share_held", 1'b0, shared_clock_line_en);
    input_at_start = 1'b1;
    step;
    chk("share_back", 1'b1, shared_clock_line_en);
    chk("ungated", 2'h3, out_enable);
    // Re-on during turn-off: channel 0 short-cycles, channel 1 follows
    h_u.xfer(1'b1, 1'b0, PCCR_CMD_CHAN_CFG, 1'b0, 1'b0, 8'h18);
    chan_cmd_on = 2'h0;
    chan_in_toff = 2'h3;
    step;
    chan_cmd_on = 2'h3;
    // Mid-cycle look at the re-on cycle itself
    @(negedge ref_clk);
    chk("reon", 2'h2, out_enable);
    n0 = 0;
    for (int i = 0; i < 20; i++) begin
      step;
      if (out_enable[0] !== 1'b1)
        n0++;
    end
    chk("min_off", 9'h00a, 9'(n0));
    chan_in_toff = 2'h0;
    // Reset in mid-run brings the defaults back
    arst_n = 1'b0;
    repeat (2) step;
    chk("busy_rst", 1'b0, busy_fault);
    arst_n = 1'b1;
    h_u.xfer(1'b0, 1'b1, PCCR_CMD_CLOCKING, 1'b0, 1'b0, 8'h00);
    chk("clk_rst", PCCR_RST_CLOCKING, rd_data);
    h_u.xfer(1'b0, 1'b1, PCCR_CMD_MODE, 1'b1, 1'b0, 8'h00);
    chk("mode_rst", PCCR_RST_MODE, rd_data);
    end_of_test;
  end
endmodule
